// File: hdl/fsps_pkg.sv
/*
  fsps_pkg: constants shared by the flash self-program sequencer.
  assumes a 16k byte flash behind a simple byte port and a 20 MHz clock.
*/
package fsps_pkg;
  localparam int fsps_addr_w = 14;
  localparam int fsps_page_bits = 9;
  localparam int fsps_page_bytes = 512;
  localparam logic [13:0] fsps_flash_top = 14'h3fff;
  localparam logic [13:0] fsps_loader_step = 14'h0200;
  localparam logic [3:0] fsps_loader_max_steps = 4'hf;
  // register offsets on the byte bus
  localparam logic [2:0] fsps_off_data = 3'h2;
  localparam logic [2:0] fsps_off_addr_hi = 3'h3;
  localparam logic [2:0] fsps_off_addr_lo = 3'h4;
  localparam logic [2:0] fsps_off_mode = 3'h5;
  localparam logic [2:0] fsps_off_cmd = 3'h6;
  localparam logic [2:0] fsps_off_ctrl = 3'h7;
  localparam logic [2:0] fsps_off_low_bound = 3'h1;
  localparam logic [2:0] fsps_off_status = 3'h0;
  // reset values
  localparam logic [7:0] fsps_data_rst = 8'hff;
  localparam logic [7:0] fsps_zero_rst = 8'h00;
  // mode codes
  localparam logic [2:0] fsps_op_standby = 3'h0;
  localparam logic [2:0] fsps_op_read = 3'h1;
  localparam logic [2:0] fsps_op_program = 3'h2;
  localparam logic [2:0] fsps_op_erase = 3'h3;
  // unlock bytes
  localparam logic [7:0] fsps_key_first = 8'h46;
  localparam logic [7:0] fsps_key_second = 8'hb9;
  // control bits
  localparam int fsps_ctrl_enable_bit = 7;
  localparam logic [2:0] fsps_swr_to_app = 3'h1;
  localparam logic [2:0] fsps_swr_to_app_hw = 3'h5;
  localparam logic [2:0] fsps_swr_to_loader = 3'h7;
  // timing of flash operations
  localparam int fsps_clk_mhz = 20;
  localparam int fsps_prog_time_us = 30;
  localparam int fsps_erase_time_us = 4000;
  localparam int fsps_read_time_ns = 100;
  localparam int fsps_prog_cycles = fsps_prog_time_us * fsps_clk_mhz;
  localparam int fsps_erase_cycles = fsps_erase_time_us * fsps_clk_mhz;
  localparam int fsps_read_cycles = (fsps_read_time_ns * fsps_clk_mhz + 999) / 1000;
endpackage

// File: hdl/fsps_sequencer.sv
/*
  fsps_sequencer: flash self-program sequencer with region checks and boot select.
  holds the byte register file, the two-byte unlock, the region checks, the
  operation timer that freezes the core, and the boot region selection.
  assumes the cpu drives the byte register port synchronously to ref_clk,
  a flash array that takes a one-cycle request with command, address and data held,
  and reset events that arrive asynchronously and are filtered here.
*/
`timescale 1ns/100ps
`default_nettype none
module fsps_sequencer #(
  parameter int erase_cycles = fsps_pkg::fsps_erase_cycles,
  parameter int prog_cycles = fsps_pkg::fsps_prog_cycles,
  parameter int read_cycles = fsps_pkg::fsps_read_cycles
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] opt_loader_size,
  input wire logic [7:0] opt_low_bound,
  input wire logic power_on_loader_boot,
  input wire logic ext_reset_loader_boot,
  input wire logic por_event,
  input wire logic ext_reset_event,
  input wire logic [13:0] cpu_fetch_addr,
  output logic [13:0] flash_fetch_addr,
  output logic core_freeze,
  output logic sw_reset_req,
  output logic in_loader,
  output logic flash_req,
  output logic [1:0] flash_cmd,
  output logic [13:0] flash_addr,
  output logic [7:0] flash_wdata,
  input wire logic [7:0] flash_rdata
);
  typedef enum logic [1:0] {fsps_idle, fsps_armed, fsps_busy} fsps_state_t;

  typedef struct packed {
    fsps_state_t state;
    logic [7:0] data;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [2:0] mode;
    logic [7:0] ctrl;
    logic [7:0] low_bound;
    logic [7:0] rdata;
    logic [2:0] op;
    logic [16:0] count;
    logic freeze;
    logic swr;
    logic loader;
    logic flash_req;
    logic [1:0] flash_cmd;
    logic [13:0] flash_addr;
    logic [7:0] flash_wdata;
    logic [13:0] fetch;
    logic [2:0] por_sync;
    logic [2:0] ext_sync;
    logic opt_loaded;
  } fsps_regs_t;

  fsps_regs_t r;
  fsps_regs_t next_r;

  // loader start address from the option, wraps to zero when disabled
  function automatic logic [13:0] fsps_loader_start(input logic [3:0] steps);
    fsps_loader_start = 14'(fsps_pkg::fsps_flash_top + 14'h0001
      - 14'(steps * fsps_pkg::fsps_loader_step));
  endfunction

  // operation length in clocks, picked by the mode at trigger time
  function automatic logic [16:0] fsps_op_length(input logic [2:0] m);
    unique case (m)
      fsps_pkg::fsps_op_erase: fsps_op_length = 17'(erase_cycles);
      fsps_pkg::fsps_op_program: fsps_op_length = 17'(prog_cycles);
      default: fsps_op_length = 17'(read_cycles);
    endcase
  endfunction

  logic [13:0] loader_start;
  logic [13:0] data_low;
  logic [13:0] target;
  logic [13:0] target_raw;
  logic below_loader;
  logic above_low;
  logic target_ok;
  logic key_ok;
  logic key_second_hit;
  logic op_enabled;
  logic mode_valid;
  logic loader_present;
  logic boot_opt_loader;
  logic boot_ext_loader;
  logic swr_app_hit;
  logic swr_loader_hit;
  logic por_seen;
  logic ext_seen;
  logic [16:0] op_len;

  always_comb
  begin
    loader_start = fsps_loader_start(opt_loader_size);
    loader_present = opt_loader_size != 4'h0;
    data_low = {r.low_bound[6:0], 7'h00};
    target_raw = {r.addr_hi[5:0], r.addr_lo};
    target = target_raw;
    if (r.mode == fsps_pkg::fsps_op_erase)
    begin
      target = {target_raw[13:9], 9'h000};
    end
    // upper limit is the byte below loader_start (no target passes with the loader disabled), lower limit only from application
    below_loader = target < loader_start;
    above_low = target >= data_low;
    target_ok = below_loader && (r.loader || above_low);
    key_ok = reg_wr && reg_addr == fsps_pkg::fsps_off_cmd;
    key_second_hit = key_ok && reg_wdata == fsps_pkg::fsps_key_second;
    op_enabled = r.ctrl[fsps_pkg::fsps_ctrl_enable_bit];
    mode_valid = r.mode != fsps_pkg::fsps_op_standby
      && r.mode <= fsps_pkg::fsps_op_erase;
    boot_opt_loader = power_on_loader_boot && loader_present;
    boot_ext_loader = boot_opt_loader && ext_reset_loader_boot;
    swr_app_hit = reg_wdata[7:5] == fsps_pkg::fsps_swr_to_app
      || (reg_wdata[7:5] == fsps_pkg::fsps_swr_to_app_hw && r.loader);
    swr_loader_hit = reg_wdata[7:5] == fsps_pkg::fsps_swr_to_loader && !r.loader
      && !power_on_loader_boot && loader_present;
    // an event counts only once the second and third stage agree
    por_seen = r.por_sync[2] && r.por_sync[1];
    ext_seen = r.ext_sync[2] && r.ext_sync[1];
    op_len = fsps_op_length(r.mode);
  end

  always_comb
  begin
    next_r = r;
    next_r.swr = 1'b0;
    next_r.flash_req = 1'b0;
    next_r.por_sync = {r.por_sync[1:0], por_event};
    next_r.ext_sync = {r.ext_sync[1:0], ext_reset_event};
    // loader offset added to every fetch while in loader
    next_r.fetch = r.loader ? 14'(cpu_fetch_addr + loader_start) : cpu_fetch_addr;
    if (!r.opt_loaded)
    begin
      next_r.opt_loaded = 1'b1;
      next_r.low_bound = opt_low_bound;
      next_r.loader = boot_opt_loader;
    end
    // filtered power-on event picks the boot region again
    if (por_seen)
    begin
      next_r.loader = boot_opt_loader;
    end
    if (ext_seen && boot_ext_loader)
    begin
      next_r.loader = 1'b1;
    end
    if (reg_wr && r.state != fsps_busy)
    begin
      unique case (reg_addr)
        fsps_pkg::fsps_off_data: next_r.data = reg_wdata;
        fsps_pkg::fsps_off_addr_hi: next_r.addr_hi = reg_wdata;
        fsps_pkg::fsps_off_addr_lo: next_r.addr_lo = reg_wdata;
        fsps_pkg::fsps_off_mode: next_r.mode = reg_wdata[2:0];
        fsps_pkg::fsps_off_low_bound:
        begin
          if (!r.loader)
          begin
            next_r.low_bound = reg_wdata;
          end
        end
        fsps_pkg::fsps_off_ctrl:
        begin
          next_r.ctrl = reg_wdata;
          if (swr_app_hit)
          begin
            next_r.swr = 1'b1;
            next_r.loader = 1'b0;
          end
          else if (swr_loader_hit)
          begin
            next_r.swr = 1'b1;
            next_r.loader = 1'b1;
          end
        end
        default:
        begin
        end
      endcase
    end
    unique case (r.state)
      fsps_idle:
      begin
        if (key_ok && reg_wdata == fsps_pkg::fsps_key_first)
        begin
          next_r.state = fsps_armed;
        end
      end
      fsps_armed:
      begin
        if (key_ok)
        begin
          next_r.state = fsps_idle;
          if (key_second_hit && op_enabled && mode_valid && target_ok)
          begin
            next_r.state = fsps_busy;
            next_r.freeze = 1'b1;
            next_r.op = r.mode;
            next_r.count = op_len;
            next_r.flash_req = 1'b1;
            next_r.flash_cmd = r.mode[1:0];
            next_r.flash_addr = target;
            // program can only clear bits; erase is the only way back to ones
            next_r.flash_wdata = r.data;
          end
          else if (reg_wdata == fsps_pkg::fsps_key_first)
          begin
            next_r.state = fsps_armed;
          end
        end
      end
      fsps_busy:
      begin
        if (r.count <= 17'h00001)
        begin
          next_r.state = fsps_idle;
          next_r.freeze = 1'b0;
          if (r.op == fsps_pkg::fsps_op_read)
          begin
            next_r.data = flash_rdata;
          end
        end
        else
        begin
          next_r.count = 17'(r.count - 17'h00001);
        end
      end
      // the fourth state code is unused; fall back to idle and release the core
      default:
      begin
        next_r.state = fsps_idle;
        next_r.freeze = 1'b0;
      end
    endcase
    if (reg_rd)
    begin
      unique case (reg_addr)
        fsps_pkg::fsps_off_data: next_r.rdata = r.data;
        fsps_pkg::fsps_off_addr_hi: next_r.rdata = r.addr_hi;
        fsps_pkg::fsps_off_addr_lo: next_r.rdata = r.addr_lo;
        fsps_pkg::fsps_off_mode: next_r.rdata = {5'h00, r.mode};
        fsps_pkg::fsps_off_ctrl: next_r.rdata = {r.ctrl[7], 7'h00};
        fsps_pkg::fsps_off_low_bound: next_r.rdata = r.low_bound;
        fsps_pkg::fsps_off_status: next_r.rdata = {5'h00, r.loader, r.state == fsps_busy,
          r.state == fsps_armed};
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      r.state <= fsps_idle;
      r.data <= fsps_pkg::fsps_data_rst;
      r.addr_hi <= fsps_pkg::fsps_zero_rst;
      r.addr_lo <= fsps_pkg::fsps_zero_rst;
      r.mode <= fsps_pkg::fsps_op_standby;
      r.ctrl <= fsps_pkg::fsps_zero_rst;
      r.low_bound <= fsps_pkg::fsps_zero_rst;
      r.rdata <= fsps_pkg::fsps_zero_rst;
      r.op <= fsps_pkg::fsps_op_standby;
      r.count <= 17'h00000;
      r.freeze <= 1'b0;
      r.swr <= 1'b0;
      // region is chosen from the options in the first cycle after release
      r.loader <= 1'b0;
      r.flash_req <= 1'b0;
      r.flash_cmd <= 2'h0;
      r.flash_addr <= 14'h0000;
      r.flash_wdata <= fsps_pkg::fsps_zero_rst;
      r.fetch <= 14'h0000;
      r.por_sync <= 3'h0;
      r.ext_sync <= 3'h0;
      r.opt_loaded <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign flash_fetch_addr = r.fetch;
  assign core_freeze = r.freeze;
  assign sw_reset_req = r.swr;
  assign in_loader = r.loader;
  assign flash_req = r.flash_req;
  assign flash_cmd = r.flash_cmd;
  assign flash_addr = r.flash_addr;
  assign flash_wdata = r.flash_wdata;
endmodule
`default_nettype wire

// File: testbench/fsps_flash_model.sv
/*
  16k byte flash array behind the sequencer's flash port.
  assumes requests are one-cycle pulses with address and data held.
*/
`timescale 1ns/100ps
`default_nettype none
module fsps_flash_model (
  input wire logic ref_clk,
  input wire logic flash_req,
  input wire logic [1:0] flash_cmd,
  input wire logic [13:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  output logic [7:0] flash_rdata
);
  logic [7:0] mem [0:16383];
  initial foreach (mem[i]) mem[i] = 8'hff;
  always @(posedge ref_clk)
    if (flash_req && flash_cmd == 2'h2)
      mem[flash_addr] <= mem[flash_addr] & flash_wdata;
    else if (flash_req && flash_cmd == 2'h3)
      for (int i = 0; i < 512; i++)
        mem[{flash_addr[13:9], 9'(i)}] <= 8'hff;
  // inverted outside reads so stale data never looks right
  assign flash_rdata = (flash_cmd == 2'h1) ? mem[flash_addr] : ~mem[flash_addr];
endmodule
`default_nettype wire

// File: testbench/fsps_sequencer_bench.sv
/*
  self-checking bench for the flash sequencer with a flash array model.
  assumes short operation counts: erase 20, program 5, read 2 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_self_program_sequencer_bench;
  logic ref_clk, rst, reg_wr, reg_rd, po_boot, er_boot, por_event, ext_reset_event;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, flash_wdata, flash_rdata;
  logic [13:0] cpu_fetch_addr, flash_fetch_addr, flash_addr;
  logic core_freeze, sw_reset_req, in_loader, flash_req;
  logic [1:0] flash_cmd;
  int mismatches = 0;
  int checks_done = 0;
  fsps_sequencer #(.erase_cycles(20), .prog_cycles(5), .read_cycles(2)) uut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .opt_loader_size(4'h2),
    .opt_low_bound(8'h70), .power_on_loader_boot(po_boot), .ext_reset_loader_boot(er_boot),
    .por_event(por_event), .ext_reset_event(ext_reset_event), .cpu_fetch_addr(cpu_fetch_addr),
    .flash_fetch_addr(flash_fetch_addr), .core_freeze(core_freeze),
    .sw_reset_req(sw_reset_req), .in_loader(in_loader), .flash_req(flash_req),
    .flash_cmd(flash_cmd), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_rdata(flash_rdata));
  fsps_flash_model fm (.ref_clk(ref_clk), .flash_req(flash_req), .flash_cmd(flash_cmd),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata));
  always #25 ref_clk = ~ref_clk;
  task automatic conclude;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // brk puts a stray byte between the two keys
  task automatic op(input logic [7:0] ctl, input logic [2:0] md, input logic [13:0] a,
    input logic [7:0] d, input logic brk, input logic run);
    int n;
    wr(fsps_pkg::fsps_off_ctrl, ctl);
    wr(fsps_pkg::fsps_off_mode, {5'h0, md});
    wr(fsps_pkg::fsps_off_addr_hi, {2'h0, a[13:8]});
    wr(fsps_pkg::fsps_off_addr_lo, a[7:0]);
    wr(fsps_pkg::fsps_off_data, d);
    wr(fsps_pkg::fsps_off_cmd, fsps_pkg::fsps_key_first);
    if (brk)
      wr(fsps_pkg::fsps_off_cmd, 8'h00);
    wr(fsps_pkg::fsps_off_cmd, fsps_pkg::fsps_key_second);
    @(negedge ref_clk);
    cmp(14'(core_freeze), 14'(run));
    n = 0;
    // core-side inputs stay held while frozen, as a level source must
    while (core_freeze !== 1'b0 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    cmp(14'(n < 100), 14'h1);
    wr(fsps_pkg::fsps_off_mode, fsps_pkg::fsps_op_standby);
    wr(fsps_pkg::fsps_off_ctrl, 8'h00);
  endtask
  task automatic chk(input logic [13:0] a, input logic [7:0] e);
    op(8'h80, fsps_pkg::fsps_op_read, a, 8'h00, 1'b0, 1'b1);
    @(posedge ref_clk);
    reg_addr <= fsps_pkg::fsps_off_data;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    cmp(14'(reg_rdata), 14'(e));
  endtask
  task automatic region(input logic e);
    int n;
    n = 0;
    while (in_loader !== e && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    cmp(14'(in_loader), 14'(e));
  endtask
  task automatic t_data_ops;
    op(8'h80, 3'h2, 14'h3804, 8'h5a, 1'b0, 1'b1);
    chk(14'h3804, 8'h5a);
    op(8'h80, 3'h2, 14'h3804, 8'h0f, 1'b0, 1'b1);
    chk(14'h3804, 8'h0a);
    op(8'h80, 3'h3, 14'h3800, 8'h00, 1'b0, 1'b1);
    chk(14'h39ff, 8'hff);
    chk(14'h3804, 8'hff);
  endtask
  task automatic t_refusals;
    op(8'h00, 3'h2, 14'h3810, 8'h00, 1'b0, 1'b0);
    op(8'h80, 3'h2, 14'h1000, 8'h00, 1'b0, 1'b0);
    op(8'h80, 3'h2, 14'h3c00, 8'h00, 1'b0, 1'b0);
    op(8'h80, 3'h2, 14'h3810, 8'h00, 1'b1, 1'b0);
    chk(14'h3810, 8'hff);
  endtask
  task automatic t_loader;
    wr(fsps_pkg::fsps_off_ctrl, 8'he0);
    region(1'b1);
    op(8'h80, 3'h2, 14'h1000, 8'h33, 1'b0, 1'b1);
    chk(14'h1000, 8'h33);
    @(posedge ref_clk);
    cpu_fetch_addr <= 14'h0010;
    repeat (2) @(negedge ref_clk);
    cmp(flash_fetch_addr, 14'h3c10);
    wr(fsps_pkg::fsps_off_ctrl, 8'h20);
    region(1'b0);
  endtask
  task automatic t_boot_opts;
    @(posedge ref_clk);
    po_boot <= 1'b1;
    por_event <= 1'b1;
    repeat (6) @(posedge ref_clk);
    por_event <= 1'b0;
    region(1'b1);
    wr(fsps_pkg::fsps_off_ctrl, 8'ha0);
    region(1'b0);
    @(posedge ref_clk);
    er_boot <= 1'b1;
    ext_reset_event <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ext_reset_event <= 1'b0;
    region(1'b1);
  endtask
  initial
  begin
    #500000;
    mismatches++;
    conclude();
  end
  initial
  begin
    {ref_clk, reg_wr, reg_rd, po_boot, er_boot, por_event, ext_reset_event} = '0;
    {reg_addr, reg_wdata, cpu_fetch_addr} = '0;
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_data_ops();
    t_refusals();
    t_loader();
    t_boot_opts();
    conclude();
  end
endmodule
`default_nettype wire

// File: testbench/fsps_sequencer_monitor.sv
/*
  port checks for the flash sequencer.
  assumes one clock, rst async high; bound to every sequencer instance.
*/
`timescale 1ns/100ps
`default_nettype none
module fsps_monitor #(
  parameter int erase_cycles = 1,
  parameter int prog_cycles = 1,
  parameter int read_cycles = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [3:0] opt_loader_size,
  input wire logic [13:0] cpu_fetch_addr,
  input wire logic [13:0] flash_fetch_addr,
  input wire logic core_freeze,
  input wire logic sw_reset_req,
  input wire logic in_loader,
  input wire logic flash_req,
  input wire logic [1:0] flash_cmd,
  input wire logic [13:0] flash_addr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [31:0] len;
  logic [13:0] ldr_start;
  // wraps to zero when the loader is disabled, hence the size test below
  assign ldr_start = 14'h0 - {1'b0, opt_loader_size, 9'h0};
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      len <= '0;
    else if (!core_freeze)
      len <= '0;
    else
      len <= len + 1;
  a_unlock_key: assert property ($rose(core_freeze) |-> $past(reg_wr && reg_wdata == 8'hb9 &&
    reg_addr == fsps_pkg::fsps_off_cmd)) else $error("freeze without unlock");
  a_req_at_freeze: assert property ($rose(core_freeze) |-> flash_req)
    else $error("no flash request at freeze");
  a_req_single: assert property (flash_req |=> core_freeze && !flash_req)
    else $error("flash request repeated");
  a_cmd_known: assert property (flash_req |-> flash_cmd != 2'h0)
    else $error("flash request without operation");
  a_erase_page: assert property (flash_req && flash_cmd == 2'h3 |-> flash_addr[8:0] == 9'h0)
    else $error("erase not page aligned");
  a_below_loader: assert property (flash_req |-> opt_loader_size == 4'h0 ||
    flash_addr < ldr_start) else $error("target in loader region");
  a_freeze_len: assert property ($fell(core_freeze) |-> len == erase_cycles ||
    len == prog_cycles || len == read_cycles) else $error("freeze length wrong");
  a_loader_fetch: assert property (in_loader |=>
    flash_fetch_addr == 14'($past(cpu_fetch_addr) + $past(ldr_start))) else $error("fetch offset");
  a_app_fetch: assert property (!in_loader |=> flash_fetch_addr == $past(cpu_fetch_addr))
    else $error("app fetch offset");
  a_loader_size: assert property ($rose(in_loader) |-> opt_loader_size != 4'h0)
    else $error("loader entered with no loader");
  a_reset_pulse: assert property (sw_reset_req |=> !sw_reset_req)
    else $error("reset request too long");
  c_erase: cover property (flash_req && flash_cmd == 2'h3);
  c_to_loader: cover property ($rose(in_loader));
  c_to_app: cover property ($fell(in_loader));
endmodule
bind fsps_sequencer fsps_monitor #(.erase_cycles(erase_cycles), .prog_cycles(prog_cycles),
  .read_cycles(read_cycles)) mon (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .opt_loader_size(opt_loader_size),
  .cpu_fetch_addr(cpu_fetch_addr), .flash_fetch_addr(flash_fetch_addr),
  .core_freeze(core_freeze), .sw_reset_req(sw_reset_req), .in_loader(in_loader),
  .flash_req(flash_req), .flash_cmd(flash_cmd), .flash_addr(flash_addr));
`default_nettype wire
